// [include/ncp_defines.svh]
// Constants for the noncachable instruction prefetch buffer
`ifndef NCP_DEFINES_SVH
`define NCP_DEFINES_SVH
`define NCP_LINE_WORDS 8
`define NCP_IDX_HI     4
`define NCP_IDX_LO     2
`define NCP_DW_HI      4
`define NCP_DW_LO      3
`define NCP_TAG_LO     5
`define NCP_SPD_BIT    16
`define NCP_LAST_BEAT  3'h7
`define NCP_FIRST_BEAT 3'h0
`define NCP_FIFO_DEPTH 16
`define NCP_WORD_LSBS  2'h0
`endif

// [include/ncp_pkg.sv]
// Types shared by the prefetch buffer modules
package ncp_pkg;
    typedef enum logic [4:0] {
        S_IDLE   = 5'h01,
        S_REQ    = 5'h02,
        S_FILL   = 5'h04,
        S_DRAIN  = 5'h08,
        S_SINGLE = 5'h10
    } ncp_state_e;

    typedef enum logic [2:0] {
        K_LINEFILL  = 3'h0,
        K_NC_LOAD   = 3'h1,
        K_NB_STORE  = 3'h2,
        K_IFETCH    = 3'h3,
        K_LOCKED    = 3'h4,
        K_DESC      = 3'h5,
        K_BUF_STORE = 3'h6,
        K_CASTOUT   = 3'h7
    } ncp_kind_e;
endpackage : ncp_pkg

// [include/ncp_stream_if.sv]
// Valid/ready stream between the bus side and the fill logic
interface ncp_stream_if #(parameter int W = 33);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ncp_stream_if

// [logic/ncp_fifo.sv]
// Read-beat FIFO between the instruction bus and the fill logic
module ncp_fifo
    import ncp_pkg::*;
#(
    parameter int W     = 33,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Streams
    ncp_stream_if.snk  in_s,
    ncp_stream_if.src  out_s,
    // Fill level
    output logic [AW:0] level
);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  wr_d;
    logic [AW:0]  rd_q;
    logic [AW:0]  rd_d;
    logic         push;
    logic         pop;

    always_comb begin
        level       = wr_q - rd_q;
        in_s.ready  = (level != (AW+1)'(DEPTH));
        out_s.valid = (wr_q != rd_q);
        out_s.data  = mem_q[rd_q[AW-1:0]];
        push        = in_s.valid && in_s.ready;
        pop         = out_s.valid && out_s.ready;
        wr_d        = push ? wr_q + 1'b1 : wr_q;
        rd_d        = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_s.data;
        end
    end
endmodule : ncp_fifo

// [logic/ncp_abort_class.sv]
// Precise and imprecise external abort classification
module ncp_abort_class
    import ncp_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // Abort events
    input  wire logic      abort_in,
    input  wire ncp_kind_e kind,
    input  wire logic      ldst_issue,
    // Reports
    output logic           precise_o,
    output logic           imprecise_o,
    output logic           fsr_imprecise_o
);
    logic pend_q;
    logic pend_d;
    logic prec_d;
    logic imp_d;
    logic fsr_d;
    logic is_imp;

    always_comb begin
        is_imp = (kind == K_BUF_STORE) || (kind == K_CASTOUT);
        prec_d = abort_in && !is_imp;
        imp_d  = ldst_issue && pend_q;
        // A new abort in the same cycle as the take stays pending
        pend_d = (pend_q && !imp_d) || (abort_in && is_imp);
        fsr_d  = fsr_o_next(fsr_imprecise_o, prec_d, imp_d);
    end

    function automatic logic fsr_o_next(input logic cur, input logic p, input logic i);
        fsr_o_next = i ? 1'b1 : (p ? 1'b0 : cur);
    endfunction : fsr_o_next

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q          <= 1'b0;
            precise_o       <= 1'b0;
            imprecise_o     <= 1'b0;
            fsr_imprecise_o <= 1'b0;
        end else begin
            pend_q          <= pend_d;
            precise_o       <= prec_d;
            imprecise_o     <= imp_d;
            fsr_imprecise_o <= fsr_d;
        end
    end

    a_precise_kinds: assert property (@(posedge clk) disable iff (rst)
        abort_in && (kind inside {K_LINEFILL, K_NC_LOAD, K_NB_STORE, K_IFETCH, K_LOCKED, K_DESC})
        |=> precise_o && !imprecise_o)
        else $error("precise abort kind not reported precisely");
    a_imprecise_next: assert property (@(posedge clk) disable iff (rst)
        abort_in && is_imp ##1 ldst_issue |=> imprecise_o && fsr_imprecise_o)
        else $error("imprecise abort not attached to next load or store");
    c_imprecise: cover property (@(posedge clk) disable iff (rst) imprecise_o);
endmodule : ncp_abort_class

// [logic/ncp_prefetch_top.sv]
// Noncachable instruction prefetch buffer with streaming and abort handling
// Behaviour
// - Speculative prefetch is on after reset with no setup.
// - Override bit 16 set turns speculative prefetch off.
// - While off, only explicit core fetches go to the bus.
// - Buffer holds eight words of one 32-byte aligned line.
// - Line stays valid until a fetch misses, then refills from target.
// - Demanded word is requested first; later matching words stream out.
// - Disable becoming set or a line mismatch invalidates the buffer.
// - Control changes such as cache or MMU enable invalidate it.
// - Instruction memory barrier invalidates; no stale words follow, except a single fetch already in flight.
// - Disabled fetches block for the bus; errors become prefetch aborts.
// - Enabled, an abort reaches the core only with the demanded word.
// - Abort during fill invalidates; refill restarts at pending demand.
// - Precise abort: older work completes, younger stays restartable.
// - Listed loads, stores, fetches, locks, descriptors abort precisely.
// - Buffered stores and castouts abort imprecisely on next load/store.
// - Aborts resolve per 64-bit doubleword regardless of bus width.
// - Critical doubleword abort: line never valid, later beats dropped.
`include "ncp_defines.svh"
module ncp_prefetch_top
    import ncp_pkg::*;
#(
    parameter int ADDR_W     = 32,
    parameter int DATA_W     = 32,
    parameter int FIFO_DEPTH = `NCP_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RESET,
    // Control state
    input  wire logic [31:0]       DBG_OVERRIDE,
    input  wire logic              CTRL_CHANGE,
    input  wire logic              INSTR_BARRIER,
    // Core fetch
    input  wire logic              FETCH_REQ,
    input  wire logic [ADDR_W-1:0] FETCH_ADDR,
    output logic                   FETCH_VALID,
    output logic [DATA_W-1:0]      FETCH_INSTR,
    output logic                   FETCH_ABORT,
    // Instruction bus request
    output logic                   BUS_REQ,
    output logic [ADDR_W-1:0]      BUS_ADDR,
    output logic                   BUS_BURST,
    input  wire logic              BUS_GNT,
    // Instruction bus read beats
    input  wire logic              BUS_RVALID,
    input  wire logic [DATA_W-1:0] BUS_RDATA,
    input  wire logic              BUS_RERR,
    output logic                   BUS_RREADY,
    // Data-side aborts
    input  wire logic              DATA_ABORT,
    input  wire ncp_kind_e         DATA_ABORT_KIND,
    input  wire logic              LDST_ISSUE,
    output logic                   PRECISE_ABORT,
    output logic                   IMPRECISE_ABORT,
    output logic                   FAULT_IMPRECISE
);
    localparam int LW = $clog2(FIFO_DEPTH);

    ncp_state_e                  state_q, state_d;
    logic [DATA_W-1:0]           line_q [`NCP_LINE_WORDS];
    logic [`NCP_LINE_WORDS-1:0]  wvalid_q, wvalid_d;
    logic                        lvalid_q, lvalid_d;
    logic [ADDR_W-1:`NCP_TAG_LO] tag_q, tag_d;
    logic [2:0]                  crit_q, crit_d;
    logic [2:0]                  cnt_q, cnt_d;
    logic                        spd_q;
    logic                        doom_q, doom_d;
    logic                        fv_d, fa_d, req_d, burst_d, rready_d;
    logic [DATA_W-1:0]           fi_d;
    logic [ADDR_W-1:0]           addr_d;
    logic                        spd, kill, tag_hit, hit, demand, beat, beat_err, wr_en;
    logic [2:0]                  idx, widx;
    logic [DATA_W-1:0]           beat_data;
    logic [LW:0]                 level;

    ncp_stream_if #(.W(DATA_W+1)) bin ();
    ncp_stream_if #(.W(DATA_W+1)) bout ();

    // Registered ready leaves two slots for the beats already in flight
    assign bin.valid  = BUS_RVALID && BUS_RREADY;
    assign bin.data   = {BUS_RERR, BUS_RDATA};
    assign bout.ready = (state_q == S_FILL) || (state_q == S_DRAIN) || (state_q == S_SINGLE);

    ncp_fifo #(.W(DATA_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk   (REF_CLK),
        .rst   (RESET),
        .in_s  (bin),
        .out_s (bout),
        .level (level)
    );

    ncp_abort_class u_abort (
        .clk             (REF_CLK),
        .rst             (RESET),
        .abort_in        (DATA_ABORT),
        .kind            (DATA_ABORT_KIND),
        .ldst_issue      (LDST_ISSUE),
        .precise_o       (PRECISE_ABORT),
        .imprecise_o     (IMPRECISE_ABORT),
        .fsr_imprecise_o (FAULT_IMPRECISE)
    );

    always_comb begin
        spd       = DBG_OVERRIDE[`NCP_SPD_BIT];
        kill      = (spd && !spd_q) || CTRL_CHANGE || INSTR_BARRIER;
        idx       = FETCH_ADDR[`NCP_IDX_HI:`NCP_IDX_LO];
        widx      = 3'(crit_q + cnt_q);
        beat      = bout.valid && bout.ready;
        beat_err  = bout.data[DATA_W];
        beat_data = bout.data[DATA_W-1:0];
        tag_hit   = (FETCH_ADDR[ADDR_W-1:`NCP_TAG_LO] == tag_q);
        hit       = FETCH_REQ && !FETCH_VALID && tag_hit && !kill && !spd
                    && (lvalid_q || (state_q == S_FILL && wvalid_q[idx]));
        demand    = FETCH_REQ && !FETCH_VALID && tag_hit
                    && (idx[2:1] == widx[2:1]);
        state_d   = state_q;
        wvalid_d  = wvalid_q;
        lvalid_d  = lvalid_q;
        tag_d     = tag_q;
        crit_d    = crit_q;
        cnt_d     = cnt_q;
        doom_d    = doom_q;
        req_d     = BUS_REQ;
        addr_d    = BUS_ADDR;
        burst_d   = BUS_BURST;
        fv_d      = 1'b0;
        fa_d      = 1'b0;
        fi_d      = FETCH_INSTR;
        wr_en     = 1'b0;
        rready_d  = (level <= (LW+1)'(FIFO_DEPTH - 2));
        if (hit) begin
            fv_d = 1'b1;
            fi_d = line_q[idx];
        end
        case (state_q)
            S_IDLE: begin
                if (kill) begin
                    lvalid_d = 1'b0;
                    wvalid_d = '0;
                end else if (FETCH_REQ && !FETCH_VALID && !hit) begin
                    lvalid_d = 1'b0;
                    wvalid_d = '0;
                    req_d    = 1'b1;
                    addr_d   = {FETCH_ADDR[ADDR_W-1:`NCP_IDX_LO], `NCP_WORD_LSBS};
                    burst_d  = !spd;
                    tag_d    = FETCH_ADDR[ADDR_W-1:`NCP_TAG_LO];
                    crit_d   = idx;
                    doom_d   = 1'b0;
                    state_d  = S_REQ;
                end
            end
            S_REQ: begin
                if (kill) begin
                    doom_d = 1'b1;
                end
                if (BUS_GNT) begin
                    req_d   = 1'b0;
                    cnt_d   = `NCP_FIRST_BEAT;
                    state_d = !BUS_BURST ? S_SINGLE : ((kill || doom_q) ? S_DRAIN : S_FILL);
                end
            end
            S_FILL: begin
                if (beat) begin
                    wr_en = 1'b1;
                    wvalid_d[widx] = 1'b1;
                    cnt_d = 3'(cnt_q + 1'b1);
                    if (cnt_q == `NCP_LAST_BEAT) begin
                        lvalid_d = !beat_err;
                        state_d  = S_IDLE;
                    end
                    if (beat_err) begin
                        wvalid_d = '0;
                        lvalid_d = 1'b0;
                        state_d  = (cnt_q == `NCP_LAST_BEAT) ? S_IDLE : S_DRAIN;
                        if (demand) begin
                            fv_d = 1'b1;
                            fa_d = 1'b1;
                        end
                    end
                end
                // Any change of target or control throws the fill away
                if (kill || (FETCH_REQ && !FETCH_VALID && !tag_hit)) begin
                    wvalid_d = '0;
                    lvalid_d = 1'b0;
                    if (!(beat && cnt_q == `NCP_LAST_BEAT)) begin
                        state_d = S_DRAIN;
                    end
                end
            end
            S_DRAIN: begin
                if (beat) begin
                    cnt_d = 3'(cnt_q + 1'b1);
                    if (cnt_q == `NCP_LAST_BEAT) begin
                        state_d = S_IDLE;
                    end
                end
            end
            S_SINGLE: begin
                if (beat) begin
                    fv_d    = 1'b1;
                    fi_d    = beat_data;
                    fa_d    = beat_err;
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_q     <= S_IDLE;
            wvalid_q    <= '0;
            lvalid_q    <= 1'b0;
            tag_q       <= '0;
            crit_q      <= `NCP_FIRST_BEAT;
            cnt_q       <= `NCP_FIRST_BEAT;
            spd_q       <= 1'b0;
            doom_q      <= 1'b0;
            FETCH_VALID <= 1'b0;
            FETCH_INSTR <= '0;
            FETCH_ABORT <= 1'b0;
            BUS_REQ     <= 1'b0;
            BUS_ADDR    <= '0;
            BUS_BURST   <= 1'b0;
            BUS_RREADY  <= 1'b0;
        end else begin
            state_q     <= state_d;
            wvalid_q    <= wvalid_d;
            lvalid_q    <= lvalid_d;
            tag_q       <= tag_d;
            crit_q      <= crit_d;
            cnt_q       <= cnt_d;
            spd_q       <= spd;
            doom_q      <= doom_d;
            FETCH_VALID <= fv_d;
            FETCH_INSTR <= fi_d;
            FETCH_ABORT <= fa_d;
            BUS_REQ     <= req_d;
            BUS_ADDR    <= addr_d;
            BUS_BURST   <= burst_d;
            BUS_RREADY  <= rready_d;
        end
        if (wr_en) begin
            line_q[widx] <= beat_data;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    a_spd_no_burst: assert property ($rose(BUS_REQ) && spd_q |-> !BUS_BURST)
        else $error("speculative burst issued while prefetch disabled");
    a_crit_first: assert property ($rose(BUS_REQ) && BUS_BURST |-> BUS_ADDR[`NCP_IDX_HI:`NCP_IDX_LO] == crit_q)
        else $error("burst does not start at demanded word");
    a_ctrl_inval: assert property ((CTRL_CHANGE || INSTR_BARRIER) |=> !lvalid_q && wvalid_q == '0)
        else $error("control change left buffer valid");
    a_barrier_stale: assert property (INSTR_BARRIER && state_q != S_SINGLE |=> !(FETCH_VALID && !FETCH_ABORT))
        else $error("instruction delivered after barrier");
    a_abort_inval: assert property (state_q == S_FILL && beat && beat_err |=> !lvalid_q && wvalid_q == '0)
        else $error("aborted fill left buffer valid");
    a_single_blocks: assert property (state_q == S_SINGLE && beat |=> FETCH_VALID && FETCH_ABORT == $past(beat_err))
        else $error("blocking fetch response wrong");
    a_abort_crit: assert property (FETCH_ABORT |-> $past(beat) && $past(beat_err))
        else $error("abort reported without erroring beat");
    a_valid_full: assert property ($rose(lvalid_q) |-> $past(state_q) == S_FILL && $past(cnt_q) == `NCP_LAST_BEAT)
        else $error("line valid before full fill");
    a_drain_inval: assert property (state_q == S_DRAIN |=> !lvalid_q)
        else $error("drained fill marked valid");
    a_spd_inval: assert property (spd && !spd_q |=> !lvalid_q)
        else $error("disable did not invalidate");

    c_stream_hit: cover property (state_q == S_FILL && hit);
    c_fill_abort: cover property (FETCH_VALID && FETCH_ABORT && BUS_BURST);
    c_line_hit: cover property (state_q == S_IDLE && lvalid_q && hit);
    c_single: cover property (state_q == S_SINGLE ##[1:20] FETCH_VALID);
endmodule : ncp_prefetch_top

// [testbench/ncp_bus_model.sv]
// Instruction bus memory model that answers line fills and single fetches
module ncp_bus_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Request side
    input  wire logic        bus_req,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_burst,
    output logic             bus_gnt,
    // Read beats
    output logic             bus_rvalid,
    output logic [31:0]      bus_rdata,
    output logic             bus_rerr,
    input  wire logic        bus_rready,
    // Test controls
    input  wire logic [2:0]  slow,
    input  wire logic        err_en,
    input  wire logic [2:0]  err_word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        req_s;
    logic        burst_s;
    logic        rdy_s;
    logic        e_s;
    logic [2:0]  ew_s;
    logic [31:0] addr_s;
    logic [31:0] a;
    logic [2:0]  w;
    int          n;

    // Registered design outputs are stable at the falling edge, so no race with the rising one
    always @(negedge clk) begin
        req_s = bus_req;
        addr_s = bus_addr;
        burst_s = bus_burst;
        rdy_s = bus_rready;
    end

    initial begin
        bus_gnt = 1'b0;
        bus_rvalid = 1'b0;
        bus_rerr = 1'b0;
        bus_rdata = 32'h0000_0000;
        e_s = 1'b0;
        ew_s = 3'h0;
        forever begin
            @(posedge clk);
            if (!rst && req_s) begin
                a = addr_s;
                // Error setting is latched per request so a draining older fill never picks up a new one
                e_s = err_en;
                ew_s = err_word;
                n = burst_s ? 8 : 1;
                repeat (slow) @(posedge clk);
                #1 bus_gnt = 1'b1;
                @(posedge clk);
                #1 bus_gnt = 1'b0;
                for (int i = 0; i < n; i++) begin
                    w = a[4:2] + 3'(i);
                    bus_rvalid = 1'b1;
                    bus_rdata = {a[31:5], w, 2'h0} ^ 32'h5A5A_C3C3;
                    bus_rerr = e_s && (ew_s == w);
                    do @(posedge clk); while (!rdy_s);
                    #1;
                    if (i == n - 1 || slow != 3'h0) begin
                        // Idle bus shows changing data, alternating between the inverted last beat and the last beat itself
                        bus_rvalid = 1'b0;
                        bus_rerr = 1'b0;
                        bus_rdata = ~bus_rdata;
                        repeat (slow) begin
                            @(posedge clk);
                            #1 bus_rdata = ~bus_rdata;
                        end
                    end
                end
            end
        end
    end
endmodule : ncp_bus_model

// [testbench/ncp_prefetch_top_tb.sv]
// Self-checking bench for the noncachable instruction prefetch buffer
`include "ncp_defines.svh"
module ncp_prefetch_top_tb
    import ncp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset, ctrl_change, barrier, fetch_req, fetch_valid, fetch_abort;
    logic        bus_req, bus_burst, bus_gnt, bus_rvalid, bus_rerr, bus_rready;
    logic        data_abort, ldst, precise, imprecise, fault_imp, err_en, last_burst;
    logic [31:0] dbg, fetch_addr, fetch_instr, bus_addr, bus_rdata, last_addr;
    logic [2:0]  slow, err_word;
    ncp_kind_e   kind;
    int          failures, n_tests, n_req, b;

    ncp_prefetch_top #(.ADDR_W(32), .DATA_W(32), .FIFO_DEPTH(16)) u_ncp_prefetch_top (
        .REF_CLK(clk), .RESET(reset), .DBG_OVERRIDE(dbg), .CTRL_CHANGE(ctrl_change),
        .INSTR_BARRIER(barrier), .FETCH_REQ(fetch_req), .FETCH_ADDR(fetch_addr),
        .FETCH_VALID(fetch_valid), .FETCH_INSTR(fetch_instr), .FETCH_ABORT(fetch_abort),
        .BUS_REQ(bus_req), .BUS_ADDR(bus_addr), .BUS_BURST(bus_burst), .BUS_GNT(bus_gnt),
        .BUS_RVALID(bus_rvalid), .BUS_RDATA(bus_rdata), .BUS_RERR(bus_rerr),
        .BUS_RREADY(bus_rready), .DATA_ABORT(data_abort), .DATA_ABORT_KIND(kind),
        .LDST_ISSUE(ldst), .PRECISE_ABORT(precise), .IMPRECISE_ABORT(imprecise),
        .FAULT_IMPRECISE(fault_imp)
    );

    ncp_bus_model u_ncp_bus_model (
        .clk(clk), .rst(reset), .bus_req(bus_req), .bus_addr(bus_addr), .bus_burst(bus_burst),
        .bus_gnt(bus_gnt), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata), .bus_rerr(bus_rerr),
        .bus_rready(bus_rready), .slow(slow), .err_en(err_en), .err_word(err_word)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Accepted bus requests; read before the design's updates of this edge land
    always @(posedge clk) begin
        if (bus_req && bus_gnt) begin
            n_req++;
            last_addr = bus_addr;
            last_burst = bus_burst;
        end
    end

    task automatic give_verdict();
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One core fetch; checks abort flag and, without abort, the instruction
    task automatic fx(input logic [31:0] a, input logic eab);
        int k;
        @(posedge clk);
        #1 fetch_req = 1'b1;
        fetch_addr = a;
        for (k = 0; k < 400 && fetch_valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == 400) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
            give_verdict();
        end else begin
            fetch_req = 1'b0;
            chk(fetch_abort, eab);
            if (!eab) begin
                chk(fetch_instr, {a[31:2], 2'h0} ^ 32'h5A5A_C3C3);
            end
        end
    endtask : fx

    task automatic s_stream();
        b = n_req;
        fx(32'h1000_0014, 1'b0);
        chk(last_addr, 32'h1000_0014);
        chk(last_burst, 1'b1);
        for (int i = 0; i < 8; i++) begin
            fx(32'h1000_0000 + 32'(4 * i), 1'b0);
        end
        chk(n_req - b, 1);
        fx(32'h1000_0020, 1'b0);
        chk(n_req - b, 2);
    endtask : s_stream

    task automatic s_disable();
        b = n_req;
        dbg = 32'h0001_1000;
        fx(32'h1000_0020, 1'b0);
        chk(last_burst, 1'b0);
        fx(32'h1000_0020, 1'b0);
        chk(n_req - b, 2);
        err_en = 1'b1;
        err_word = 3'h0;
        fx(32'h1000_0020, 1'b1);
        err_en = 1'b0;
        dbg = 32'h0000_1000;
        fx(32'h1000_0024, 1'b0);
        chk(n_req - b, 4);
    endtask : s_disable

    // Kill a slow fill mid-way by barrier, then by control change
    task automatic s_kill();
        slow = 3'h2;
        for (int j = 0; j < 2; j++) begin
            b = n_req;
            fx(32'h2000_0000 + 32'(64 * j), 1'b0);
            barrier = (j == 0);
            ctrl_change = (j == 1);
            @(posedge clk);
            #1 barrier = 1'b0;
            ctrl_change = 1'b0;
            fx(32'h2000_0004 + 32'(64 * j), 1'b0);
            chk(n_req - b, 2);
            fx(32'h2000_0008 + 32'(64 * j), 1'b0);
            chk(n_req - b, 2);
        end
        slow = 3'h0;
    endtask : s_kill

    task automatic s_abort();
        b = n_req;
        err_en = 1'b1;
        err_word = 3'h2;
        fx(32'h3000_0008, 1'b1);
        err_en = 1'b0;
        fx(32'h3000_0008, 1'b0);
        chk(n_req - b, 2);
        #1 err_en = 1'b1;
        err_word = 3'h3;
        fx(32'h3000_0028, 1'b1);
        err_en = 1'b0;
        #1 err_en = 1'b1;
        err_word = 3'h6;
        fx(32'h3000_0048, 1'b0);
        fx(32'h3000_0044, 1'b0);
        chk(n_req - b, 5);
        err_en = 1'b0;
    endtask : s_abort

    // Kinds 6 and 7 first, so the first precise report must clear the status
    task automatic s_data();
        int kk;
        for (int k = 0; k < 8; k++) begin
            kk = (k + 6) % 8;
            @(posedge clk);
            #1 data_abort = 1'b1;
            kind = ncp_kind_e'(kk);
            @(posedge clk);
            #1 data_abort = 1'b0;
            chk(precise, kk < 6);
            chk(imprecise, 1'b0);
            if (kk >= 6) begin
                ldst = 1'b1;
                @(posedge clk);
                #1 chk(imprecise, 1'b1);
                chk(fault_imp, 1'b1);
                @(posedge clk);
                #1 ldst = 1'b0;
                chk(imprecise, 1'b0);
            end else begin
                chk(fault_imp, 1'b0);
            end
        end
    endtask : s_data

    initial begin
        reset = 1'b1;
        {ctrl_change, barrier, fetch_req, data_abort, ldst, err_en} = '0;
        dbg = 32'h0000_1000;
        fetch_addr = 32'h0000_0000;
        kind = K_LINEFILL;
        slow = 3'h0;
        err_word = 3'h0;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        s_stream();
        s_disable();
        s_kill();
        s_abort();
        s_data();
        give_verdict();
    end
endmodule : ncp_prefetch_top_tb
